// ==== rtl/epi_consts.svh ====
// Purpose: Constants for the external pin interrupt block
// Assumes: APB, 32-bit data, word-aligned registers
// Notes:   Offsets are byte addresses
// What this block does
// - Mode 1: falling edge sets latch, low pin keeps request active.
// - Mode 1: clear needs acknowledge and pin high, either order.
// - Mode 1: request stays asserted while pin low, even after acknowledge.
// - Vector fetch produces an acknowledge pulse clearing the latch.
// - Software writing one to acknowledge bit clears like a vector fetch.
// - Falling edge after acknowledge write latches a new request.
// - Mask clear presents request to CPU; mask set withholds it.
// - Any reset clears latch and mode bit, even with pin low.
// - Mode 0: only falling edges count, steady low ignored.
// - Mode 0: acknowledge clears latch at once, pin level irrelevant.
// - Pending flag shows latch state regardless of mask.
// - Pin level observable for branch-if-pin-high/low.
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH
`define EPI_OFS_CTRL      12'h000
`define EPI_OFS_STAT      12'h004
`define EPI_OFS_EVMSK     12'h008
`define EPI_OFS_PIN       12'h00C
`define EPI_CTRL_MODE     0
`define EPI_CTRL_MASK     1
`define EPI_CTRL_ACK      2
`define EPI_CTRL_PEND     3
`define EPI_EV_REQ        0
`define EPI_EV_ACK        1
`define EPI_NUM_EV        2
`define EPI_CTRL_RST      4'h0
`define EPI_DATA_ZERO     32'h0000_0000
`endif

// ==== rtl/epi_edge_if.sv ====
// Purpose: Carrier between pin front end and latch logic
// Assumes: Single clock pclk
// Notes:   fall is a one-cycle pulse
interface epi_edge_if;
   logic fall;
   logic level;
   modport src (output fall, output level);
   modport dst (input fall, input level);
endinterface

// ==== rtl/epi_pin_sync.sv ====
// Purpose: Synchronise the pin and detect falling edges
// Assumes: Pin is asynchronous to pclk
// Notes:   First flop feeds only the second flop
module epi_pin_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_in,
   epi_edge_if.src   edge_o
);
   import epi_pkg::*;
   logic       s1_reg, s2_reg, s1_next, s2_next;
   logic [1:0] warm_reg, warm_next;
   epi_edge_t  st_reg, st_next;
   logic       fall_reg, fall_next;

   // Next state: one pulse per high-to-low transition
   always_comb begin
      s1_next   = pin_in;
      s2_next   = s1_reg;
      warm_next = {warm_reg[0], 1'b1};
      st_next   = st_reg;
      fall_next = 1'b0;
      case (st_reg)
         EPI_WAIT_HIGH: if (s2_reg && warm_reg[1]) st_next = EPI_ARMED;
         EPI_ARMED: if (!s2_reg) begin
            fall_next = 1'b1;
            st_next   = EPI_HELD_LOW;
         end
         EPI_HELD_LOW: if (s2_reg) st_next = EPI_ARMED;
         default: st_next = EPI_WAIT_HIGH;
      endcase
   end

   // Sync flops idle high; arming waits until both hold real pin samples,
   // otherwise a pin held low through reset would look like a fresh edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg   <= 1'b1;
         s2_reg   <= 1'b1;
         st_reg   <= EPI_WAIT_HIGH;
         fall_reg <= 1'b0;
         warm_reg <= 2'h0;
      end else begin
         s1_reg   <= s1_next;
         s2_reg   <= s2_next;
         st_reg   <= st_next;
         fall_reg <= fall_next;
         warm_reg <= warm_next;
      end
   end

   assign edge_o.fall  = fall_reg;
   assign edge_o.level = s2_reg;
endmodule

// ==== rtl/epi_pkg.sv ====
// Purpose: Types for the external pin interrupt block
// Assumes: Nothing beyond the constants header
// Notes:   Edge detector state kept as an enum
package epi_pkg;
   typedef enum logic [1:0] {EPI_WAIT_HIGH, EPI_ARMED, EPI_HELD_LOW} epi_edge_t;
   typedef logic [31:0] epi_word_t;
endpackage

// ==== rtl/epi_top.sv ====
// Purpose: External pin interrupt with APB registers
// Assumes: pclk 20 MHz, presetn async low, APB3 slave
// Notes:   Zero wait states; unmapped reads zero, writes ignored
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`include "epi_consts.svh"
module epi_top (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire epi_pkg::epi_word_t pwdata,
   output logic                 pready,
   output logic                 pslverr,
   output epi_pkg::epi_word_t   prdata,
   input  wire logic            irq_pin,
   input  wire logic            vector_fetch,
   output logic                 cpu_irq_req,
   output logic                 pin_level,
   output logic                 irq_out
);
   import epi_pkg::*;

   epi_edge_if pe ();
   epi_pin_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (irq_pin),
      .edge_o  (pe)
   );

   logic                      mode_reg, mode_next;
   logic                      pin_interrupt_mask_reg, pin_interrupt_mask_next;
   logic                      latch_reg, latch_next;
   logic                      ackd_reg, ackd_next;
   logic [`EPI_NUM_EV-1:0]    ev_stat_reg, ev_stat_next;
   logic [`EPI_NUM_EV-1:0]    ev_mask_reg, ev_mask_next;
   logic [`EPI_NUM_EV-1:0]    ev_set;
   epi_word_t                 prdata_reg, prdata_next;
   logic                      req_reg, req_next;
   logic                      lvl_reg, lvl_next;
   logic                      irq_reg, irq_next;
   logic                      wr, rd, ack_wr, ack;

   // APB strobes; access phase completes in one cycle
   assign wr     = psel & penable & pwrite;
   assign rd     = psel & penable & ~pwrite;
   assign ack_wr = wr && paddr == `EPI_OFS_CTRL && pwdata[`EPI_CTRL_ACK];
   assign ack    = ack_wr | vector_fetch;

   // Events for the status register
   assign ev_set[`EPI_EV_REQ] = pe.fall;
   assign ev_set[`EPI_EV_ACK] = ack;

   // Control and request latch next state
   always_comb begin
      mode_next               = mode_reg;
      pin_interrupt_mask_next = pin_interrupt_mask_reg;
      latch_next              = latch_reg;
      ackd_next               = ackd_reg;
      if (wr && paddr == `EPI_OFS_CTRL) begin
         mode_next               = pwdata[`EPI_CTRL_MODE];
         pin_interrupt_mask_next = pwdata[`EPI_CTRL_MASK];
      end
      if (!mode_reg) begin
         ackd_next = 1'b0;
         if (ack) latch_next = 1'b0;
      end else begin
         // Acknowledge remembered until pin returns high
         if (ack && latch_reg) ackd_next = 1'b1;
         if (ackd_next && pe.level) begin
            latch_next = 1'b0;
            ackd_next  = 1'b0;
         end
         if (!pe.level && latch_reg) latch_next = 1'b1;
      end
      // New edge wins over any clear in the same cycle
      if (pe.fall) begin
         latch_next = 1'b1;
         ackd_next  = 1'b0;
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   genvar g;
   generate
      for (g = 0; g < `EPI_NUM_EV; g++) begin : g_ev
         always_comb begin
            ev_stat_next[g] = ev_stat_reg[g];
            if (wr && paddr == `EPI_OFS_STAT && pwdata[g]) ev_stat_next[g] = 1'b0;
            if (ev_set[g]) ev_stat_next[g] = 1'b1;
         end
      end
   endgenerate

   // Event mask register, one enables the event
   always_comb begin
      ev_mask_next = ev_mask_reg;
      if (wr && paddr == `EPI_OFS_EVMSK) ev_mask_next = pwdata[`EPI_NUM_EV-1:0];
   end

   // Read mux and registered outputs
   always_comb begin
      prdata_next = prdata_reg;
      if (psel && !penable && !pwrite) begin
         prdata_next = `EPI_DATA_ZERO;
         case (paddr)
            `EPI_OFS_CTRL: begin
               prdata_next[`EPI_CTRL_MODE] = mode_reg;
               prdata_next[`EPI_CTRL_MASK] = pin_interrupt_mask_reg;
               prdata_next[`EPI_CTRL_PEND] = latch_reg;
            end
            `EPI_OFS_STAT:  prdata_next[`EPI_NUM_EV-1:0] = ev_stat_reg;
            `EPI_OFS_EVMSK: prdata_next[`EPI_NUM_EV-1:0] = ev_mask_reg;
            `EPI_OFS_PIN:   prdata_next[0] = pe.level;
            default:        prdata_next = `EPI_DATA_ZERO;
         endcase
      end
      req_next = latch_next & ~pin_interrupt_mask_next;
      lvl_next = pe.level;
      irq_next = |(ev_stat_next & ev_mask_next);
   end

   // All state registers; reset clears latch and mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg               <= 1'b0;
         pin_interrupt_mask_reg <= 1'b0;
         latch_reg              <= 1'b0;
         ackd_reg               <= 1'b0;
         ev_stat_reg            <= '0;
         ev_mask_reg            <= '0;
         prdata_reg             <= `EPI_DATA_ZERO;
         req_reg                <= 1'b0;
         lvl_reg                <= 1'b1;
         irq_reg                <= 1'b0;
      end else begin
         mode_reg               <= mode_next;
         pin_interrupt_mask_reg <= pin_interrupt_mask_next;
         latch_reg              <= latch_next;
         ackd_reg               <= ackd_next;
         ev_stat_reg            <= ev_stat_next;
         ev_mask_reg            <= ev_mask_next;
         prdata_reg             <= prdata_next;
         req_reg                <= req_next;
         lvl_reg                <= lvl_next;
         irq_reg                <= irq_next;
      end
   end

   assign pready      = 1'b1;   // Zero wait states
   assign pslverr     = 1'b0;
   assign prdata      = prdata_reg;
   assign cpu_irq_req = req_reg;
   assign pin_level   = lvl_reg;
   assign irq_out     = irq_reg;
endmodule

// ==== verif/epi_cpu_model.sv ====
// Purpose: CPU side that answers a request with a vector fetch
// Assumes: One clock, async low reset
// Notes:   lat sets how slowly the CPU answers
module epi_cpu_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       en,
   input  wire logic [3:0] lat,
   input  wire logic       cpu_irq_req,
   output logic            vector_fetch
);
   timeunit 1ns / 1ns;
   logic [3:0] cnt;
   logic       done;
   logic       fire;
   // One fetch per request, none again while it stays up
   assign fire = en && cpu_irq_req && !done && cnt == lat;
   // Fetch pulse lasts one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         done <= 1'b0;
         vector_fetch <= 1'b0;
      end else begin
         vector_fetch <= fire;
         done <= cpu_irq_req && (done || fire);
         cnt <= !cpu_irq_req ? 4'h0 : cnt + {3'h0, en && cnt != lat};
      end
   end
endmodule

// ==== verif/epi_top_sva.sv ====
// Purpose: Port checks for the pin interrupt block
// Assumes: One clock, async low reset
// Notes:   Helpers track pin run length and recent bus or fetch activity
module epi_top_sva (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire epi_pkg::epi_word_t prdata,
   input wire logic               irq_pin,
   input wire logic               vector_fetch,
   input wire logic               cpu_irq_req,
   input wire logic               pin_level,
   input wire logic               irq_out
);
   timeunit 1ns / 1ns;
   import epi_pkg::*;
   logic [3:0] run_cnt;
   logic       run_lvl;
   logic [2:0] busy;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pin run length saturates so long quiet spells stay cheap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cnt <= 4'h0;
         run_lvl <= 1'b1;
         busy <= 3'h0;
      end else begin
         run_lvl <= irq_pin;
         run_cnt <= (irq_pin != run_lvl) ? 4'h0 : run_cnt + {3'h0, run_cnt != 4'hF};
         busy <= {busy[1:0], psel | vector_fetch};
      end
   end
   apb_resp_a: assert property (pready && !pslverr) else $error("bus response wrong");
   pin_track_a: assert property (run_cnt >= 4'h4 |-> pin_level == run_lvl)
      else $error("pin level not tracked");
   reset_clear_a: assert property (disable iff (1'b0) !presetn |-> !cpu_irq_req && !irq_out)
      else $error("request seen in reset");
   ack_clear_a: assert property (vector_fetch && run_lvl && run_cnt >= 4'h6 |-> ##2 !cpu_irq_req)
      else $error("fetch did not clear request");
   hold_low_a: assert property (cpu_irq_req && !run_lvl && run_cnt >= 4'h4
      && busy == 3'h0 && !psel && !vector_fetch |=> cpu_irq_req) else $error("request dropped");
   irq_fall_a: assert property ($fell(irq_out) |-> $past(psel && pwrite, 2) || $past(psel && pwrite))
      else $error("irq dropped without write");
   rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
      else $error("read data moved");
   rise_cause_a: assert property ($rose(cpu_irq_req) |-> run_cnt <= 4'h6 || $past(psel, 2))
      else $error("request without cause");
   fetch_c: cover property (vector_fetch && cpu_irq_req);
   irq_c: cover property ($rose(irq_out));
   low_c: cover property ($fell(pin_level));
endmodule
bind epi_top epi_top_sva chk (.*);

// ==== verif/tb_external_pin_interrupt.sv ====
// Purpose: Self-checking bench for the pin interrupt block
// Assumes: 50 ns clock, reset held two cycles, seed 85
// Notes:   Pin held steady at least five cycles so sync delay is covered
`include "epi_consts.svh"
module tb_external_pin_interrupt;
   timeunit 1ns / 1ns;
   import epi_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_pin;
   logic        vector_fetch, cpu_irq_req, pin_level, irq_out, cpu_en, md, mk;
   logic [11:0] paddr;
   logic [3:0]  cpu_lat;
   epi_word_t   pwdata, prdata, rd;
   int          num_errors, samples_checked, i;
   epi_top dut (.*);
   epi_cpu_model cpu (.pclk(pclk), .presetn(presetn), .en(cpu_en), .lat(cpu_lat),
      .cpu_irq_req(cpu_irq_req), .vector_fetch(vector_fetch));
   // Free-running bus clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   function automatic epi_word_t ctl(input logic m, input logic k, input logic p);
      return {28'h000_0000, p, 1'b0, k, m};
   endfunction
   task automatic give_verdict;
      if (num_errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input epi_word_t e, input epi_word_t g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Idle edge first, so psel is never assigned twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input epi_word_t d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      chk("pslverr", `EPI_DATA_ZERO, epi_word_t'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         chk("pready", 32'h0000_0001, 32'h0000_0000);
         give_verdict();
      end
   endtask
   task automatic rdc(input logic [11:0] a, input epi_word_t e, input string nm);
      apb(1'b0, a, `EPI_DATA_ZERO);
      chk(nm, e, rd);
   endtask
   task automatic wreq(input logic e);
      int n;
      for (n = 0; n < 20 && cpu_irq_req !== e; n++) @(posedge pclk);
      chk("cpu_irq_req", epi_word_t'(e), epi_word_t'(cpu_irq_req));
      if (n == 20) give_verdict();
   endtask
   task automatic pin(input logic v);
      irq_pin <= v;
      repeat (6) @(posedge pclk);
   endtask
   // Directed corner cases, then random mode and mask mixes
   initial begin
      {presetn, psel, penable, pwrite, irq_pin, cpu_en} = 6'h02;
      {paddr, pwdata, cpu_lat, num_errors, samples_checked} = '0;
      i = $urandom(85);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`EPI_OFS_CTRL, ctl(0, 0, 0), "ctrl reset");
      rdc(`EPI_OFS_PIN, 32'h0000_0001, "pin high");
      chk("pin_level high", 1, epi_word_t'(pin_level));
      rdc(12'h010, `EPI_DATA_ZERO, "unmapped");
      apb(1'b1, `EPI_OFS_EVMSK, 32'h0000_0002);
      rdc(`EPI_OFS_EVMSK, 32'h0000_0002, "event mask");
      pin(1'b0);
      wreq(1'b1);
      chk("irq masked", 0, epi_word_t'(irq_out));
      apb(1'b1, `EPI_OFS_CTRL, 32'h0000_0004);
      repeat (5) @(posedge pclk);
      chk("irq ack", 1, epi_word_t'(irq_out));
      rdc(`EPI_OFS_CTRL, ctl(0, 0, 0), "low ignored");
      rdc(`EPI_OFS_PIN, `EPI_DATA_ZERO, "pin low");
      chk("pin_level low", 0, epi_word_t'(pin_level));
      rdc(`EPI_OFS_STAT, 32'h0000_0003, "status");
      apb(1'b1, `EPI_OFS_STAT, 32'h0000_0003);
      rdc(`EPI_OFS_STAT, `EPI_DATA_ZERO, "status clr");
      chk("irq clr", 0, epi_word_t'(irq_out));
      pin(1'b1);
      pin(1'b0);
      wreq(1'b1);
      cpu_en <= 1'b1;
      wreq(1'b0);
      cpu_en <= 1'b0;
      pin(1'b1);
      apb(1'b1, `EPI_OFS_CTRL, ctl(0, 1, 0));
      pin(1'b0);
      rdc(`EPI_OFS_CTRL, ctl(0, 1, 1), "pend masked");
      chk("req masked", 0, epi_word_t'(cpu_irq_req));
      apb(1'b1, `EPI_OFS_CTRL, ctl(1, 0, 0));
      wreq(1'b1);
      apb(1'b1, `EPI_OFS_CTRL, 32'h0000_0005);
      repeat (5) @(posedge pclk);
      rdc(`EPI_OFS_CTRL, ctl(1, 0, 1), "ack low");
      pin(1'b1);
      rdc(`EPI_OFS_CTRL, ctl(1, 0, 0), "ack high");
      pin(1'b0);
      pin(1'b1);
      cpu_lat <= 4'h3;
      cpu_en <= 1'b1;
      wreq(1'b0);
      cpu_en <= 1'b0;
      pin(1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      rdc(`EPI_OFS_CTRL, ctl(0, 0, 0), "reset low");
      chk("req after reset", 0, epi_word_t'(cpu_irq_req));
      pin(1'b1);
      for (i = 0; i < 8; i++) begin
         md = 1'($urandom);
         mk = 1'($urandom);
         apb(1'b1, `EPI_OFS_CTRL, ctl(md, mk, 0));
         irq_pin <= 1'b0;
         repeat ($urandom_range(5, 9)) @(posedge pclk);
         rdc(`EPI_OFS_CTRL, ctl(md, mk, 1), "rand pend");
         chk("rand req", epi_word_t'(!mk), epi_word_t'(cpu_irq_req));
         apb(1'b1, `EPI_OFS_CTRL, ctl(md, mk, 0) | 32'h0000_0004);
         rdc(`EPI_OFS_CTRL, ctl(md, mk, md), "rand ack low");
         pin(1'b1);
         apb(1'b1, `EPI_OFS_CTRL, ctl(md, mk, 0) | 32'h0000_0004);
         rdc(`EPI_OFS_CTRL, ctl(md, mk, 0), "rand ack");
      end
      give_verdict();
   end
endmodule
